// ---- include/rsx_pkg.sv ----
// package of opcodes, flag layout and carriers for the rotate/subtract/skip unit
package rsx_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W = 13;

  // flag positions inside the 4-bit status register
  localparam int FLAG_C = 0;
  localparam int FLAG_HB = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_WRAP = 3;

  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] ONE = 8'h01;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;

  typedef enum logic [4:0] {
    RSX_NOP,
    RSX_RET_LIT,
    RSX_IRET,
    RSX_ROT_L,
    RSX_ROT_L_W,
    RSX_ROT_LC,
    RSX_ROT_LC_W,
    RSX_ROT_R,
    RSX_ROT_R_W,
    RSX_ROT_RC,
    RSX_ROT_RC_W,
    RSX_SUB_BRW,
    RSX_SUB_BRW_M,
    RSX_SUB,
    RSX_SUBM,
    RSX_SUBI,
    RSX_DEC_SKIP,
    RSX_DEC_SKIP_W,
    RSX_INC_SKIP,
    RSX_INC_SKIP_W,
    RSX_BIT_SKIP,
    RSX_SET,
    RSX_SETB,
    RSX_SWAP
  } rsx_op_t;

  // one issued instruction with its operands
  typedef struct packed {
    rsx_op_t op;
    logic [7:0] mem;
    logic [7:0] lit;
    logic [2:0] bit_sel;
    logic [PC_W-1:0] stack_top;
  } rsx_issue_t;

  // result of one instruction, before the core applies it
  typedef struct packed {
    logic wr_wreg;
    logic wr_mem;
    logic [7:0] value;
    logic [3:0] flags;
    logic [3:0] flag_we;
    logic skip;
    logic pop;
    logic gate_set;
  } rsx_result_t;

endpackage

// ---- src/rsx_sub8.sv ----
// 8-bit subtractor with borrow-in and full flag generation
`timescale 1ns/100ps
module rsx_sub8 #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] minuend,
  input wire logic [WIDTH-1:0] subtrahend,
  input wire logic carry_in,
  output logic [WIDTH-1:0] diff,
  output logic [3:0] flags
);
  logic [WIDTH:0] full;
  logic [4:0] low;
  logic borrow_in;

  // the half-borrow tap is fixed at bit 4, so only bytes are served
  if (WIDTH != 8) begin : g_bad_width
    $error("rsx_sub8 serves only 8 bits");
  end

  // carry set means no borrow pending
  assign borrow_in = ~carry_in;
  assign full = {1'b0, minuend} - {1'b0, subtrahend} -
                {{WIDTH{1'b0}}, borrow_in};
  assign low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} -
               {4'h0, borrow_in};
  assign diff = full[WIDTH-1:0];

  always_comb begin
    flags = 4'h0;
    flags[rsx_pkg::FLAG_C] = ~full[WIDTH];
    flags[rsx_pkg::FLAG_HB] = ~low[4];
    flags[rsx_pkg::FLAG_Z] = (diff == '0);
    flags[rsx_pkg::FLAG_WRAP] = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) &&
      (diff[WIDTH-1] != minuend[WIDTH-1]);
  end
endmodule

// ---- src/rsx_rot8.sv ----
// byte rotator: left or right, plain or through carry
`timescale 1ns/100ps
module rsx_rot8 (
  input wire logic [7:0] din,
  input wire logic right,
  input wire logic thru_carry,
  input wire logic carry_in,
  output logic [7:0] dout,
  output logic carry_out
);
  always_comb begin
    if (right) begin
      dout = {thru_carry ? carry_in : din[0], din[7:1]};
      carry_out = din[0];
    end else begin
      dout = {din[6:0], thru_carry ? carry_in : din[7]};
      carry_out = din[7];
    end
  end
endmodule

// ---- src/rsx_exec.sv ----
// execution unit for returns, rotates, subtracts, skips, sets and swap
`timescale 1ns/100ps
module rsx_exec #(
  parameter int PC_WIDTH = rsx_pkg::PC_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire rsx_pkg::rsx_issue_t issue,
  input wire logic irq_pending,
  input wire logic gate_clear,
  output logic busy_reg,
  output logic [7:0] wreg_reg,
  output logic [3:0] status_reg,
  output logic master_irq_gate_reg,
  output logic mem_we_reg,
  output logic [7:0] mem_wdata_reg,
  output logic pc_load_reg,
  output logic [PC_WIDTH-1:0] pc_target_reg,
  output logic stack_pop_reg,
  output logic stack_push_reg,
  output logic [PC_WIDTH-1:0] push_value_reg,
  output logic skip_reg,
  output logic irq_enter_reg
);

  rsx_pkg::rsx_result_t res;
  logic [7:0] rot_out;
  logic rot_carry;
  logic [7:0] sub_b;
  logic [7:0] sub_diff;
  logic [3:0] sub_flags;
  logic sub_cin;
  logic rot_right;
  logic rot_thru;
  logic [7:0] dec_val;
  logic [7:0] inc_val;
  logic [7:0] bit_mask;
  logic fire;
  logic iret_irq;
  logic dummy_next;

  // the stack carrier in the issue struct is fixed at the package width
  if (PC_WIDTH != rsx_pkg::PC_W) begin : g_bad_pc
    $error("rsx_exec: PC_WIDTH must match");
  end

  assign fire = issue_valid && !busy_reg;
  assign dec_val = issue.mem - rsx_pkg::ONE;
  assign inc_val = issue.mem + rsx_pkg::ONE;

  // one compare per bit position instead of a shifter
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign bit_mask[i] = (issue.bit_sel == 3'(i));
  end

  always_comb begin
    rot_right = 1'b0;
    rot_thru = 1'b0;
    case (issue.op)
      rsx_pkg::RSX_ROT_R, rsx_pkg::RSX_ROT_R_W: rot_right = 1'b1;
      rsx_pkg::RSX_ROT_RC, rsx_pkg::RSX_ROT_RC_W: begin
        rot_right = 1'b1;
        rot_thru = 1'b1;
      end
      rsx_pkg::RSX_ROT_LC, rsx_pkg::RSX_ROT_LC_W: rot_thru = 1'b1;
      default: begin
        rot_right = 1'b0;
        rot_thru = 1'b0;
      end
    endcase
  end

  rsx_rot8 u_rot (
    .din(issue.mem),
    .right(rot_right),
    .thru_carry(rot_thru),
    .carry_in(status_reg[rsx_pkg::FLAG_C]),
    .dout(rot_out),
    .carry_out(rot_carry)
  );

  // immediate form swaps the memory operand for the literal
  assign sub_b = (issue.op == rsx_pkg::RSX_SUBI) ? issue.lit : issue.mem;
  // plain subtract behaves as borrow-free: carry-in forced to one
  assign sub_cin = (issue.op == rsx_pkg::RSX_SUB_BRW ||
                    issue.op == rsx_pkg::RSX_SUB_BRW_M) ?
                   status_reg[rsx_pkg::FLAG_C] : 1'b1;

  rsx_sub8 #(
    .WIDTH(8)
  ) u_sub (
    .minuend(wreg_reg),
    .subtrahend(sub_b),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // decode: what each instruction writes, and whether it skips
  always_comb begin
    res = '0;
    case (issue.op)
      rsx_pkg::RSX_RET_LIT: begin
        res.wr_wreg = 1'b1;
        res.value = issue.lit;
        res.pop = 1'b1;
      end
      rsx_pkg::RSX_IRET: begin
        res.pop = 1'b1;
        res.gate_set = 1'b1;
      end
      rsx_pkg::RSX_ROT_L, rsx_pkg::RSX_ROT_R: begin
        res.wr_mem = 1'b1;
        res.value = rot_out;
      end
      rsx_pkg::RSX_ROT_L_W, rsx_pkg::RSX_ROT_R_W: begin
        res.wr_wreg = 1'b1;
        res.value = rot_out;
      end
      rsx_pkg::RSX_ROT_LC, rsx_pkg::RSX_ROT_RC: begin
        res.wr_mem = 1'b1;
        res.value = rot_out;
        res.flags[rsx_pkg::FLAG_C] = rot_carry;
        res.flag_we[rsx_pkg::FLAG_C] = 1'b1;
      end
      rsx_pkg::RSX_ROT_LC_W, rsx_pkg::RSX_ROT_RC_W: begin
        res.wr_wreg = 1'b1;
        res.value = rot_out;
        res.flags[rsx_pkg::FLAG_C] = rot_carry;
        res.flag_we[rsx_pkg::FLAG_C] = 1'b1;
      end
      rsx_pkg::RSX_SUB_BRW, rsx_pkg::RSX_SUB, rsx_pkg::RSX_SUBI: begin
        res.wr_wreg = 1'b1;
        res.value = sub_diff;
        res.flags = sub_flags;
        res.flag_we = 4'hf;
      end
      rsx_pkg::RSX_SUB_BRW_M, rsx_pkg::RSX_SUBM: begin
        res.wr_mem = 1'b1;
        res.value = sub_diff;
        res.flags = sub_flags;
        res.flag_we = 4'hf;
      end
      rsx_pkg::RSX_DEC_SKIP: begin
        res.wr_mem = 1'b1;
        res.value = dec_val;
        res.skip = (dec_val == 8'h00);
      end
      rsx_pkg::RSX_DEC_SKIP_W: begin
        res.wr_wreg = 1'b1;
        res.value = dec_val;
        res.skip = (dec_val == 8'h00);
      end
      rsx_pkg::RSX_INC_SKIP: begin
        res.wr_mem = 1'b1;
        res.value = inc_val;
        res.skip = (inc_val == 8'h00);
      end
      rsx_pkg::RSX_INC_SKIP_W: begin
        res.wr_wreg = 1'b1;
        res.value = inc_val;
        res.skip = (inc_val == 8'h00);
      end
      rsx_pkg::RSX_BIT_SKIP: begin
        res.skip = |(issue.mem & bit_mask);
      end
      rsx_pkg::RSX_SET: begin
        res.wr_mem = 1'b1;
        res.value = rsx_pkg::ALL_ONES;
      end
      rsx_pkg::RSX_SETB: begin
        res.wr_mem = 1'b1;
        res.value = issue.mem | bit_mask;
      end
      rsx_pkg::RSX_SWAP: begin
        // no flag_we: swap keeps every flag
        res.wr_mem = 1'b1;
        res.value = {issue.mem[3:0], issue.mem[7:4]};
      end
      default: res = '0;
    endcase
  end

  // gate is reopened by the return, so a waiting request enters at once
  assign iret_irq = fire && res.gate_set && irq_pending;
  // a skip or a pc change costs a dummy cycle while the next op is fetched
  assign dummy_next = fire && (res.skip || res.pop);

  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= dummy_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wreg_reg <= rsx_pkg::WREG_RST;
    end else if (fire && res.wr_wreg) begin
      wreg_reg <= res.value;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_reg <= rsx_pkg::STATUS_RST;
    end else if (fire) begin
      status_reg <= (status_reg & ~res.flag_we) | (res.flags & res.flag_we);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      master_irq_gate_reg <= 1'b0;
    end else if (iret_irq) begin
      // entering the pending routine closes the gate again
      master_irq_gate_reg <= 1'b0;
    end else if (fire && res.gate_set) begin
      master_irq_gate_reg <= 1'b1;
    end else if (gate_clear) begin
      master_irq_gate_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_we_reg <= 1'b0;
    end else begin
      mem_we_reg <= fire && res.wr_mem;
    end
  end

  // data follows the decoder every cycle; only the strobe qualifies it
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_wdata_reg <= 8'h00;
    end else begin
      mem_wdata_reg <= res.value;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pc_load_reg <= 1'b0;
      pc_target_reg <= rsx_pkg::PC_RST;
    end else begin
      pc_load_reg <= fire && res.pop;
      // pending interrupt: vector now, popped address goes back on stack
      pc_target_reg <= iret_irq ? rsx_pkg::IRQ_VECTOR : issue.stack_top;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      stack_pop_reg <= 1'b0;
      stack_push_reg <= 1'b0;
      push_value_reg <= rsx_pkg::PC_RST;
    end else begin
      stack_pop_reg <= fire && res.pop;
      stack_push_reg <= iret_irq;
      push_value_reg <= issue.stack_top;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_enter_reg <= 1'b0;
    end else begin
      irq_enter_reg <= iret_irq;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      skip_reg <= 1'b0;
    end else begin
      skip_reg <= fire && res.skip;
    end
  end

endmodule

// ---- dv/rsx_exec_monitor.sv ----
// assertion checker for the rotate/subtract/skip execution unit
`timescale 1ns/100ps
module rsx_exec_monitor #(
  parameter int PC_WIDTH = rsx_pkg::PC_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic issue_valid,
  input wire rsx_pkg::rsx_issue_t issue,
  input wire logic irq_pending,
  input wire logic busy_reg,
  input wire logic [7:0] wreg_reg,
  input wire logic [3:0] status_reg,
  input wire logic master_irq_gate_reg,
  input wire logic mem_we_reg,
  input wire logic [7:0] mem_wdata_reg,
  input wire logic [PC_WIDTH-1:0] pc_target_reg,
  input wire logic stack_pop_reg,
  input wire logic [PC_WIDTH-1:0] push_value_reg,
  input wire logic skip_reg,
  input wire logic irq_enter_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic tk;
  logic [7:0] m;
  rsx_pkg::rsx_op_t op;
  // an issue only counts when the unit is not in its dummy cycle
  assign tk = issue_valid && !busy_reg;
  assign m = issue.mem;
  assign op = issue.op;
  sequence s_dummy;
    busy_reg ##1 !busy_reg;
  endsequence
  property p_ret_lit;
    tk && op == rsx_pkg::RSX_RET_LIT |=> (wreg_reg == $past(issue.lit)
      && pc_target_reg == $past(issue.stack_top) && stack_pop_reg
      && $stable(status_reg)) ##0 s_dummy;
  endproperty
  a_ret_lit: assert property (p_ret_lit) else $error("literal return");
  property p_iret_open;
    tk && op == rsx_pkg::RSX_IRET && !irq_pending |=> master_irq_gate_reg
      && pc_target_reg == $past(issue.stack_top) && !irq_enter_reg;
  endproperty
  a_iret_open: assert property (p_iret_open) else $error("irq return");
  property p_iret_pend;
    tk && op == rsx_pkg::RSX_IRET && irq_pending |=> irq_enter_reg
      && pc_target_reg == rsx_pkg::IRQ_VECTOR
      && push_value_reg == $past(issue.stack_top);
  endproperty
  a_iret_pend: assert property (p_iret_pend) else $error("pending irq");
  property p_rot_l;
    tk && op == rsx_pkg::RSX_ROT_L |=> mem_we_reg && $stable(status_reg)
      && mem_wdata_reg == {$past(m[6:0]), $past(m[7])};
  endproperty
  a_rot_l: assert property (p_rot_l) else $error("rotate left");
  property p_rot_r_w;
    tk && op == rsx_pkg::RSX_ROT_R_W |=> !mem_we_reg
      && wreg_reg == {$past(m[0]), $past(m[7:1])};
  endproperty
  a_rot_r_w: assert property (p_rot_r_w) else $error("rot right");
  property p_dskip;
    tk && op == rsx_pkg::RSX_DEC_SKIP |=> mem_we_reg
      && mem_wdata_reg == $past(m) - 8'h01
      && skip_reg == ($past(m) == 8'h01);
  endproperty
  a_dskip: assert property (p_dskip) else $error("dec skip");
  property p_sub_c;
    tk && op == rsx_pkg::RSX_SUB |=>
      status_reg[0] == ($past(wreg_reg) >= $past(m));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("subtract carry");
  property p_swap;
    tk && op == rsx_pkg::RSX_SWAP |=> mem_we_reg && $stable(status_reg)
      && mem_wdata_reg == {$past(m[3:0]), $past(m[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("nibble swap");
  property p_skip;
    skip_reg |-> s_dummy;
  endproperty
  a_skip: assert property (p_skip) else $error("skip dummy cycle");
endmodule
bind rsx_exec rsx_exec_monitor #(.PC_WIDTH(PC_WIDTH)) u_mon (.mclk, .rst,
  .issue_valid, .issue, .irq_pending, .busy_reg, .wreg_reg, .status_reg,
  .master_irq_gate_reg, .mem_we_reg, .mem_wdata_reg, .pc_target_reg,
  .stack_pop_reg, .push_value_reg, .skip_reg, .irq_enter_reg);

// ---- dv/rotate_subtract_skip_exec_bench.sv ----
// self-checking bench for the rotate/subtract/skip execution unit
`timescale 1ns/100ps
module rotate_subtract_skip_exec_bench;
  logic mclk, rst, issue_valid, irq_pending, gate_clear;
  rsx_pkg::rsx_issue_t issue;
  logic busy_reg, master_irq_gate_reg, mem_we_reg, pc_load_reg;
  logic stack_pop_reg, stack_push_reg, skip_reg, irq_enter_reg;
  logic [7:0] wreg_reg, mem_wdata_reg;
  logic [3:0] status_reg;
  logic [12:0] pc_target_reg, push_value_reg;
  int n_mismatch = 0;
  int cmp_count = 0;
  rsx_exec dut (.mclk, .rst, .issue_valid, .issue, .irq_pending,
    .gate_clear, .busy_reg, .wreg_reg, .status_reg, .master_irq_gate_reg,
    .mem_we_reg, .mem_wdata_reg, .pc_load_reg, .pc_target_reg,
    .stack_pop_reg, .stack_push_reg, .push_value_reg, .skip_reg,
    .irq_enter_reg);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one instruction after an idle edge, so valid never falls and rises in
  // one step and any dummy cycle is over; result settled on return
  task automatic ex(input rsx_pkg::rsx_op_t o, input logic [7:0] m,
    input logic [7:0] l = 8'h00, input logic [2:0] b = 3'h0,
    input logic [12:0] t = 13'h0000);
    @(negedge mclk);
    issue = '{o, m, l, b, t};
    issue_valid = 1'b1;
    @(negedge mclk);
    issue_valid = 1'b0;
  endtask
  task automatic wm(input logic [7:0] d, input logic [3:0] s);
    chk(mem_we_reg, 1'b1);
    chk(mem_wdata_reg, d);
    chk(status_reg, s);
  endtask
  task automatic ww(input logic [7:0] d, input logic [3:0] s);
    chk(mem_we_reg, 1'b0);
    chk(wreg_reg, d);
    chk(status_reg, s);
  endtask
  task automatic t_sub();
    ex(rsx_pkg::RSX_RET_LIT, 8'h00, 8'h5a, 3'h0, 13'h0123);
    chk(wreg_reg, 8'h5a);
    chk(pc_target_reg, 13'h0123);
    chk({pc_load_reg, stack_pop_reg, busy_reg}, 3'h7);
    ex(rsx_pkg::RSX_SUB, 8'h5b);
    ww(8'hff, 4'h0);
    ex(rsx_pkg::RSX_SUB_BRW, 8'h01);
    ww(8'hfd, 4'h3);
    ex(rsx_pkg::RSX_SUBM, 8'hfd);
    wm(8'h00, 4'h7);
    ex(rsx_pkg::RSX_SUB_BRW_M, 8'h80);
    wm(8'h7d, 4'h3);
    ex(rsx_pkg::RSX_SUBI, 8'h00, 8'h7e);
    ww(8'h7f, 4'h9);
  endtask
  task automatic t_rot();
    ex(rsx_pkg::RSX_ROT_LC, 8'h80);
    wm(8'h01, 4'h9);
    ex(rsx_pkg::RSX_ROT_L, 8'h81);
    wm(8'h03, 4'h9);
    ex(rsx_pkg::RSX_ROT_RC, 8'h02);
    wm(8'h81, 4'h8);
    ex(rsx_pkg::RSX_ROT_R_W, 8'h01);
    ww(8'h80, 4'h8);
    ex(rsx_pkg::RSX_ROT_L_W, 8'h80);
    ww(8'h01, 4'h8);
    ex(rsx_pkg::RSX_ROT_LC_W, 8'h80);
    ww(8'h00, 4'h9);
    ex(rsx_pkg::RSX_ROT_RC_W, 8'h01);
    ww(8'h80, 4'h9);
    ex(rsx_pkg::RSX_ROT_R, 8'h01);
    wm(8'h80, 4'h9);
  endtask
  task automatic t_skip();
    @(negedge mclk);
    issue = '{rsx_pkg::RSX_DEC_SKIP, 8'h01, 8'h00, 3'h0, 13'h0000};
    issue_valid = 1'b1;
    @(negedge mclk);
    wm(8'h00, 4'h9);
    chk({skip_reg, busy_reg}, 2'h3);
    // valid held into the dummy cycle with a new op: must be ignored
    issue.op = rsx_pkg::RSX_SET;
    @(negedge mclk);
    issue_valid = 1'b0;
    chk({mem_we_reg, busy_reg}, 2'h0);
    ex(rsx_pkg::RSX_DEC_SKIP_W, 8'h05);
    ww(8'h04, 4'h9);
    chk(skip_reg, 1'b0);
    ex(rsx_pkg::RSX_DEC_SKIP_W, 8'h01);
    chk({skip_reg, mem_we_reg, wreg_reg}, 10'h200);
    ex(rsx_pkg::RSX_INC_SKIP, 8'hff);
    wm(8'h00, 4'h9);
    chk(skip_reg, 1'b1);
    ex(rsx_pkg::RSX_INC_SKIP_W, 8'h10);
    ww(8'h11, 4'h9);
    chk(skip_reg, 1'b0);
    ex(rsx_pkg::RSX_BIT_SKIP, 8'h04, 8'h00, 3'h2);
    chk({skip_reg, mem_we_reg, status_reg}, 6'h29);
    ex(rsx_pkg::RSX_BIT_SKIP, 8'hfb, 8'h00, 3'h2);
    chk({skip_reg, busy_reg}, 2'h0);
  endtask
  task automatic t_set();
    ex(rsx_pkg::RSX_SET, 8'h12);
    wm(8'hff, 4'h9);
    ex(rsx_pkg::RSX_SETB, 8'h00, 8'h00, 3'h5);
    wm(8'h20, 4'h9);
    ex(rsx_pkg::RSX_SWAP, 8'ha5);
    wm(8'h5a, 4'h9);
  endtask
  task automatic t_irq();
    ex(rsx_pkg::RSX_IRET, 8'h00, 8'h00, 3'h0, 13'h0456);
    chk({master_irq_gate_reg, stack_push_reg}, 2'h2);
    chk({pc_target_reg, status_reg}, 17'h04569);
    gate_clear = 1'b1;
    @(negedge mclk);
    gate_clear = 1'b0;
    chk(master_irq_gate_reg, 1'b0);
    irq_pending = 1'b1;
    ex(rsx_pkg::RSX_IRET, 8'h00, 8'h00, 3'h0, 13'h0789);
    irq_pending = 1'b0;
    chk(pc_target_reg, rsx_pkg::IRQ_VECTOR);
    chk(push_value_reg, 13'h0789);
    chk({stack_push_reg, irq_enter_reg, stack_pop_reg}, 3'h7);
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    rst = 1'b1;
    issue_valid = 1'b0;
    issue = '0;
    irq_pending = 1'b0;
    gate_clear = 1'b0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk({wreg_reg, status_reg, master_irq_gate_reg}, 13'h0000);
    t_sub();
    t_rot();
    t_skip();
    t_set();
    t_irq();
    wrap_up();
  end
  // the tests need about sixty cycles; allow a wide margin
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
endmodule
